// *** hw/dld_pkg.sv ***
/*
 * Shared constants and types for the digital lock detector.
 * Assumes a single 40 MHz system clock drives all detector logic.
 */
package dld_pkg;
    // =========================================================
    // Widths
    localparam int WIN_W = 8;
    localparam int CNT_W = 16;

    // =========================================================
    // Reset values
    localparam logic [WIN_W-1:0] ERR_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // =========================================================
    // Timing figures
    localparam int SYS_CLK_MHZ = 40;
    localparam int EX_PD_RATE_MHZ = 40;
    localparam int EX_LOCK_COUNT = 10000;
    localparam int EX_MIN_LOCK_US = EX_LOCK_COUNT / EX_PD_RATE_MHZ;
    localparam int EX_MIN_LOCK_CYC = EX_MIN_LOCK_US * SYS_CLK_MHZ;

    // =========================================================
    // Types
    typedef logic [WIN_W-1:0] dld_win_t;
    typedef logic [CNT_W-1:0] dld_cnt_t;
    typedef enum logic [1:0] {
        DLD_IDLE = 2'b01,
        DLD_MEAS = 2'b10
    } dld_state_t;
endpackage : dld_pkg

// *** hw/dld_cmp_if.sv ***
/*
 * Carrier between the lock detector top and one edge comparator.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/10ps
interface dld_cmp_if;
    import dld_pkg::*;
    logic ref_lvl;
    logic fb_lvl;
    dld_win_t win;
    logic ok;
    logic bad;
    modport cmp (input ref_lvl, input fb_lvl, input win, output ok,
                 output bad);
    modport user (output ref_lvl, output fb_lvl, output win, input ok,
                  input bad);
endinterface : dld_cmp_if

// *** hw/dld_phase_win.sv ***
/*
 * Edge comparator: times the gap between a divided reference edge and a
 * divided feedback edge in sys_clk cycles and grades each phase detector
 * cycle as inside or outside the window.
 * Assumes ref_lvl and fb_lvl are already synchronised to sys_clk.
 */
`timescale 1ns/10ps
module dld_phase_win (
    input wire logic sys_clk,
    input wire logic rst_n,
    dld_cmp_if.cmp cmp
);
    import dld_pkg::*;

    // =========================================================
    // Edge detection
    logic ref_d_ff;
    logic fb_d_ff;
    logic first_ref_ff;
    logic ok_ff;
    logic bad_ff;
    dld_win_t err_ff;
    dld_win_t nxt_err;
    dld_state_t state_ff;
    dld_state_t nxt_state;
    logic nxt_first_ref;
    logic nxt_ok;
    logic nxt_bad;

    wire ref_edge = cmp.ref_lvl & ~ref_d_ff;
    wire fb_edge = cmp.fb_lvl & ~fb_d_ff;
    wire other_edge = first_ref_ff ? fb_edge : ref_edge;
    wire same_edge = first_ref_ff ? ref_edge : fb_edge;
    wire [WIN_W:0] err_inc = {1'b0, err_ff} + {{WIN_W{1'b0}}, 1'b1};
    wire in_win = err_inc <= {1'b0, cmp.win};
    wire meas_done = other_edge | same_edge | ~in_win;

    // =========================================================
    // Grading
    always_comb begin
        nxt_state = state_ff;
        nxt_err = err_ff;
        nxt_first_ref = first_ref_ff;
        nxt_ok = 1'b0;
        nxt_bad = 1'b0;
        case (state_ff)
            DLD_IDLE: begin
                if (ref_edge && fb_edge) begin
                    nxt_ok = 1'b1;
                end else if (ref_edge || fb_edge) begin
                    nxt_state = DLD_MEAS;
                    nxt_err = ERR_RST;
                    nxt_first_ref = ref_edge;
                end
            end
            DLD_MEAS: begin
                nxt_err = err_inc[WIN_W-1:0];
                if (meas_done) begin
                    nxt_state = DLD_IDLE;
                    nxt_ok = other_edge & in_win; // R9
                    nxt_bad = ~(other_edge & in_win); // R7
                end
            end
            default: begin
                nxt_state = DLD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_d_ff <= 1'b0;
            fb_d_ff <= 1'b0;
            state_ff <= DLD_IDLE;
            err_ff <= ERR_RST;
            first_ref_ff <= 1'b0;
            ok_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else begin
            ref_d_ff <= cmp.ref_lvl;
            fb_d_ff <= cmp.fb_lvl;
            state_ff <= nxt_state;
            err_ff <= nxt_err;
            first_ref_ff <= nxt_first_ref;
            ok_ff <= nxt_ok;
            bad_ff <= nxt_bad;
        end
    end

    assign cmp.ok = ok_ff;
    assign cmp.bad = bad_ff;
endmodule : dld_phase_win

// *** hw/dld_lock_detect.sv ***
/*
 * Digital lock detector for a dual-loop clock conditioner: grades every
 * phase detector cycle of both loops and qualifies first-loop lock,
 * second-loop lock and holdover exit from consecutive in-window cycles.
 * Assumes divided clock pins are asynchronous and slower than sys_clk/4;
 * configuration ports and holdover_enter come from sys_clk logic.
 */
// Contract
// R1 - Three events share one scheme: two loop locks and holdover exit.
// R2 - Loops use own window and count; exit uses loop-1 window, own count.
// R3 - A loop's lock output goes true when its qualification event occurs.
// R4 - The holdover exit event takes the device out of holdover.
// R5 - An event needs count consecutive in-window phase detector cycles.
// R6 - No event fires before count phase detector cycles have been graded.
// R7 - Any out-of-window cycle clears the in-window counter to zero.
// R8 - Software sets ppm = 2e6 x window x PD rate / count by its choice.
// R9 - Effective tolerance is the window width divided by the count.
// R10 - At 40 MHz PD rate and count 10,000 loop-2 lock waits 250 us.
// R11 - Counter saturates at count; lock holds until a violation.
`timescale 1ns/10ps
module dld_lock_detect (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic first_loop_divided_reference,
    input wire logic first_loop_divided_feedback,
    input wire logic second_loop_divided_reference,
    input wire logic second_loop_divided_feedback,
    input wire dld_pkg::dld_win_t first_loop_window_width,
    input wire dld_pkg::dld_win_t second_loop_window_width,
    input wire dld_pkg::dld_cnt_t first_loop_lock_count,
    input wire dld_pkg::dld_cnt_t second_loop_lock_count,
    input wire dld_pkg::dld_cnt_t holdover_exit_count,
    input wire logic holdover_enter,
    output logic first_loop_lock,
    output logic second_loop_lock,
    output logic holdover_active,
    output logic holdover_exit_pulse
);
    import dld_pkg::*;

    function automatic dld_cnt_t sat_inc(dld_cnt_t c, dld_cnt_t lim);
        sat_inc = (c < lim) ? c + 16'h0001 : c;
    endfunction : sat_inc

    // =========================================================
    // Pin synchronisers
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    wire [3:0] pin_w = {second_loop_divided_feedback,
                        second_loop_divided_reference,
                        first_loop_divided_feedback,
                        first_loop_divided_reference};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 4'h0;
            sync_ff <= 4'h0;
        end else begin
            meta_ff <= pin_w;
            sync_ff <= meta_ff;
        end
    end

    // =========================================================
    // Edge comparators, one per loop
    logic [1:0] ok_w;
    logic [1:0] bad_w;
    dld_win_t win_w [2];
    assign win_w[0] = first_loop_window_width;
    assign win_w[1] = second_loop_window_width;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_loop
            dld_cmp_if cif ();
            assign cif.ref_lvl = sync_ff[2*g];
            assign cif.fb_lvl = sync_ff[2*g+1];
            assign cif.win = win_w[g];
            assign ok_w[g] = cif.ok;
            assign bad_w[g] = cif.bad;
            dld_phase_win u_cmp (
                .sys_clk (sys_clk),
                .rst_n (rst_n),
                .cmp (cif.cmp)
            );
        end
    endgenerate

    // =========================================================
    // Qualifiers: 0 first-loop lock, 1 second-loop lock, 2 holdover exit
    logic holdover_active_ff;
    logic holdover_exit_ff;
    logic first_lock_ff;
    logic second_lock_ff;
    dld_cnt_t tgt_w [3];
    logic [2:0] q_en;
    logic [2:0] met_w;
    assign tgt_w[0] = first_loop_lock_count; // R2
    assign tgt_w[1] = second_loop_lock_count; // R2
    assign tgt_w[2] = holdover_exit_count; // R2
    assign q_en = {holdover_active_ff, 2'b11};

    generate
        for (g = 0; g < 3; g++) begin : g_qual // R1
            localparam int LP = (g == 1) ? 1 : 0;
            dld_cnt_t cnt_ff;
            dld_cnt_t nxt_cnt;
            assign nxt_cnt = (!q_en[g] || bad_w[LP]) ? CNT_RST : // R7
                             ok_w[LP] ? sat_inc(cnt_ff, tgt_w[g]) : // R5 R11
                             cnt_ff;
            assign met_w[g] = (tgt_w[g] != CNT_RST) &&
                              (nxt_cnt >= tgt_w[g]); // R6 R10
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_ff <= CNT_RST;
                end else begin
                    cnt_ff <= nxt_cnt;
                end
            end
        end
    endgenerate

    // =========================================================
    // Lock and holdover outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_lock_ff <= 1'b0;
            second_lock_ff <= 1'b0;
            holdover_active_ff <= 1'b0;
            holdover_exit_ff <= 1'b0;
        end else begin
            first_lock_ff <= met_w[0]; // R3 R11
            second_lock_ff <= met_w[1]; // R3 R11
            holdover_exit_ff <= holdover_active_ff & met_w[2]; // R4
            if (holdover_active_ff && met_w[2]) begin
                holdover_active_ff <= 1'b0; // R4
            end else if (holdover_enter) begin
                holdover_active_ff <= 1'b1;
            end
        end
    end

    assign first_loop_lock = first_lock_ff;
    assign second_loop_lock = second_lock_ff;
    assign holdover_active = holdover_active_ff;
    assign holdover_exit_pulse = holdover_exit_ff;
endmodule : dld_lock_detect

// *** sim/dld_lock_detect_asserts.sv ***
/* Checker for the lock detector top ports.
   Assumes it is bound to every dld_lock_detect instance. */
`timescale 1ns/10ps
module dld_lock_detect_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire dld_pkg::dld_cnt_t first_loop_lock_count,
    input wire dld_pkg::dld_cnt_t second_loop_lock_count,
    input wire dld_pkg::dld_cnt_t holdover_exit_count,
    input wire logic holdover_enter,
    input wire logic first_loop_lock,
    input wire logic second_loop_lock,
    input wire logic holdover_active,
    input wire logic holdover_exit_pulse
);
    import dld_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // =========================================================
    // Holdover
    sequence s_exit_done;
        !holdover_active ##1 !holdover_exit_pulse;
    endsequence
    a_exit_leaves_hold: assert property (
        holdover_exit_pulse |-> s_exit_done) else $error("bad exit");
    a_exit_from_hold: assert property (
        $rose(holdover_exit_pulse) |-> $past(holdover_active))
        else $error("exit without holdover");
    a_enter_sets_hold: assert property (
        holdover_enter |=> holdover_active || holdover_exit_pulse)
        else $error("holdover not entered");
    a_hold_ends_exit: assert property (
        $fell(holdover_active) |-> holdover_exit_pulse)
        else $error("holdover left without exit");
    a_exit_count_set: assert property (
        holdover_exit_pulse |-> holdover_exit_count != CNT_RST)
        else $error("exit with zero count");
    // =========================================================
    // Lock
    a_lock_count_set: assert property (
        $rose(first_loop_lock) |-> first_loop_lock_count != CNT_RST)
        else $error("lock with zero count");
    a_lock1_not_early: assert property (
        $rose(first_loop_lock) && first_loop_lock_count > 16'h0001
        |-> $past(first_loop_lock, 3) == 1'b0) else $error("early lock");
    a_lock2_not_early: assert property (
        $rose(second_loop_lock) && second_loop_lock_count > 16'h0001
        |-> $past(second_loop_lock, 3) == 1'b0) else $error("early lock");
endmodule : dld_lock_detect_asserts

bind dld_lock_detect dld_lock_detect_asserts dld_lock_detect_asserts_inst (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .first_loop_lock_count(first_loop_lock_count),
    .second_loop_lock_count(second_loop_lock_count),
    .holdover_exit_count(holdover_exit_count),
    .holdover_enter(holdover_enter), .first_loop_lock(first_loop_lock),
    .second_loop_lock(second_loop_lock),
    .holdover_active(holdover_active),
    .holdover_exit_pulse(holdover_exit_pulse));

// *** sim/dld_lock_detect_bench.sv ***
/* Bench for the lock detector: drives divided pins and settings.
   Assumes the checker is bound to the design. */
`timescale 1ns/10ps
module dld_lock_detect_bench;
    import dld_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] ref_pin = 2'b00;
    logic [1:0] fb_pin = 2'b00;
    // Window and count pairs as configuring software would choose them
    dld_win_t win1 = 8'h04;
    dld_win_t win2 = 8'h01;
    dld_cnt_t cnt1 = 16'h0003;
    // Nonzero so that loop-1 grades leaking into loop 2 would show
    dld_cnt_t cnt2 = 16'h0002;
    dld_cnt_t cnt_ho = 16'h0002;
    logic enter = 1'b0;
    logic lock1, lock2, ho_act, ho_exit;
    int fails = 0;
    int n_tests = 0;
    int exits = 0;
    always #12.5 sys_clk = ~sys_clk;
    dld_lock_detect dld_lock_detect_inst (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .first_loop_divided_reference(ref_pin[0]),
        .first_loop_divided_feedback(fb_pin[0]),
        .second_loop_divided_reference(ref_pin[1]),
        .second_loop_divided_feedback(fb_pin[1]),
        .first_loop_window_width(win1), .second_loop_window_width(win2),
        .first_loop_lock_count(cnt1), .second_loop_lock_count(cnt2),
        .holdover_exit_count(cnt_ho), .holdover_enter(enter),
        .first_loop_lock(lock1), .second_loop_lock(lock2),
        .holdover_active(ho_act), .holdover_exit_pulse(ho_exit));
    always @(negedge sys_clk) if (ho_exit === 1'b1) exits++;
    task automatic chk(input logic got, input logic exp, input string s);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, s);
        end
    endtask : chk
    // n periods of 12 cycles, feedback gap cycles after reference
    task automatic pd(input int lp, input int gap, input int n);
        repeat (n) for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            ref_pin[lp] = (i < 5);
            fb_pin[lp] = (i >= gap && i < gap + 5);
        end
        // Idle lets any late edge time out before the next check
        repeat (8) @(negedge sys_clk);
    endtask : pd
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        chk(lock1, 1'b0, "lock1 after reset");
        pd(0, 3, 2);
        chk(lock1, 1'b0, "lock1 early");
        pd(0, 4, 1);
        chk(lock1, 1'b1, "lock1 missing");
        chk(lock2, 1'b0, "lock2 follows loop 1");
        pd(0, 3, 2);
        chk(lock1, 1'b1, "lock1 not held");
        pd(0, 5, 1);
        chk(lock1, 1'b0, "lock1 kept after violation");
        pd(0, 3, 2);
        chk(lock1, 1'b0, "counter not cleared");
        pd(0, 3, 1);
        chk(lock1, 1'b1, "lock1 not regained");
        cnt2 = 16'h0000;
        pd(1, 0, 3);
        chk(lock2, 1'b0, "lock2 with zero count");
        pd(1, 2, 1);
        cnt2 = 16'h0002;
        pd(1, 1, 1);
        chk(lock2, 1'b0, "lock2 early");
        pd(1, 0, 1);
        chk(lock2, 1'b1, "lock2 missing");
        pd(1, 2, 1);
        chk(lock2, 1'b0, "loop 2 window too wide");
        pd(1, 1, 1);
        chk(lock2, 1'b0, "lock2 counter not cleared");
        pd(1, 1, 1);
        chk(lock2, 1'b1, "lock2 not regained");
        enter = 1'b1;
        @(negedge sys_clk);
        enter = 1'b0;
        @(negedge sys_clk);
        chk(ho_act, 1'b1, "holdover not entered");
        pd(0, 3, 1);
        pd(0, 6, 1);
        chk(lock1, 1'b0, "lock1 kept in holdover violation");
        chk(lock2, 1'b1, "lock2 hit by loop 1 violation");
        pd(0, 3, 1);
        chk(ho_act, 1'b1, "holdover left early");
        pd(0, 3, 1);
        chk(ho_act, 1'b0, "holdover not left");
        chk(exits == 1, 1'b1, "exit pulse count");
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
endmodule : dld_lock_detect_bench
